/* pwg_guard.sv */
`timescale 1ns/10ps
`default_nettype none
module pwg_guard import pwg_pkg::*; #(
  parameter int          INST_IDX   = 0,
  parameter int          ADDR_W     = 8,
  parameter logic [31:0] PROT_RESET = PWG_PROT_RESET0,
  parameter logic [31:0] IMPL_MASK  = PWG_IMPL_MASK0
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire pwg_tgt_t    i_tgt,
  output logic             o_tgt_block,
  output logic             o_tgt_error,
  output logic      [31:0] o_prot_state,
  output logic             o_clk_on_rst
);

  if (ADDR_W < 3 || ADDR_W > 8) begin : g_chk
    $error("pwg_guard: ADDR_W must be 3..8");
  end
  if (INST_IDX < 0) begin : g_chk_inst
    $error("pwg_guard: INST_IDX must not be negative");
  end
  // A reset bit outside the mask could never be cleared again
  if ((PROT_RESET & ~IMPL_MASK) != 32'h0000_0000) begin : g_chk_rst
    $error("pwg_guard: PROT_RESET has bits outside IMPL_MASK");
  end

  // Instance index decides the power-manager clock default; gating is outside
  assign o_clk_on_rst = (INST_IDX < PWG_CLK_ON_INST);

  logic [31:0] prot_q, prot_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  ofs;
  logic        hit_clr, hit_set, hit_any;
  logic        acc_wr, setup_rd;
  logic [31:0] wbits;
  logic        dbl_err;

  // Offset compared on word boundaries; byte lanes come from the strobes
  always_comb begin
    ofs             = 8'h00;
    ofs[ADDR_W-1:2] = i_paddr[ADDR_W-1:2];
  end
  assign hit_clr  = (ofs == PWG_OFS_CLEAR);
  assign hit_set  = (ofs == PWG_OFS_SET);
  assign hit_any  = hit_clr | hit_set;
  assign acc_wr   = i_psel & i_penable & i_pwrite;
  assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
  // Only ones in enabled lanes on implemented bits count
  assign wbits    = i_pwdata & pwg_lanes(i_pstrb) & IMPL_MASK;

  // Double protect or double unprotect is reported; the write is harmless anyway
  assign dbl_err = hit_set ? |(wbits & prot_q)
                           : |(wbits & ~prot_q & IMPL_MASK);

  always_comb begin
    prot_d = prot_q;
    if (acc_wr && hit_set) begin
      prot_d = prot_q | wbits;
    end else if (acc_wr && hit_clr) begin
      prot_d = prot_q & ~wbits;
    end
  end

  // Read data is captured in the setup phase so it leaves a flip-flop
  always_comb begin
    rdata_d = rdata_q;
    if (setup_rd) begin
      rdata_d = hit_any ? (prot_q & IMPL_MASK) : 32'h0000_0000;
    end
  end

  // No sleep gating inside: state holds and checks run on every edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      prot_q <= PROT_RESET;
    end else begin
      prot_q <= prot_d;
    end
  end

  // Read data only moves on a read setup or a reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_prdata     = rdata_q;
  assign o_pready     = 1'b1;
  assign o_pslverr    = i_psel & i_penable & (~hit_any | (i_pwrite & dbl_err));
  assign o_prot_state = prot_q & IMPL_MASK;

  // One guard per bridge; idx selects the peripheral on this bridge
  always_comb begin
    o_tgt_block = i_tgt.valid & i_tgt.write & ~i_tgt.debug
                & prot_q[i_tgt.idx] & IMPL_MASK[i_tgt.idx];
    o_tgt_error = o_tgt_block;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_wr_set;
    acc_wr && hit_set;
  endsequence

  sequence s_wr_clr;
    acc_wr && hit_clr;
  endsequence

  sequence s_rd_setup;
    setup_rd && hit_any;
  endsequence

  sequence s_acc_unmapped;
    i_psel && i_penable && !hit_any;
  endsequence

  // Access on the bridge that the guard must judge
  sequence s_tgt_wr;
    i_tgt.valid && i_tgt.write && !i_tgt.debug;
  endsequence

  prot_set_a: assert property (s_wr_set |=> ((prot_q & $past(wbits)) == $past(wbits)))
    else $error("set write did not protect");
  prot_clr_a: assert property (s_wr_clr |=> ((prot_q & $past(wbits)) == 32'h0000_0000))
    else $error("clear write did not unprotect");
  zero_keep_a: assert property ((acc_wr && hit_any) |=>
                                ((prot_q & ~$past(wbits)) == ($past(prot_q) & ~$past(wbits))))
    else $error("unwritten bit changed");
  idle_hold_a: assert property (!acc_wr |=> $stable(prot_q))
    else $error("protection changed without write");
  read_same_a: assert property ((setup_rd && hit_any) |=>
                                (o_prdata == ($past(prot_q) & IMPL_MASK)))
    else $error("read value differs from protection state");
  dbl_set_a: assert property ((s_wr_set ##0 (|(wbits & prot_q))) |-> o_pslverr)
    else $error("double protect not flagged");
  dbl_clr_a: assert property ((s_wr_clr ##0 (|(wbits & ~prot_q))) |-> o_pslverr)
    else $error("double unprotect not flagged");
  block_wr_a: assert property ((i_tgt.valid && i_tgt.write && !i_tgt.debug &&
                                prot_q[i_tgt.idx] && IMPL_MASK[i_tgt.idx])
                               |-> (o_tgt_block && o_tgt_error))
    else $error("protected write not blocked");
  dbg_pass_a: assert property (i_tgt.debug |-> !o_tgt_block)
    else $error("debugger access blocked");
  read_pass_a: assert property (!i_tgt.write |-> !o_tgt_block)
    else $error("read access blocked");
  rst_value_a: assert property ($past(!i_reset_n) |-> (prot_q == PROT_RESET))
    else $error("protection reset value wrong");
  rst_state_a: assert property ($past(!i_reset_n) |->
                                (o_prot_state == (PROT_RESET & IMPL_MASK)))
    else $error("protection state after reset wrong");

  // Byte lanes, ready and unmapped offsets
  lane_gate_a: assert property ((acc_wr && hit_any) |=>
                                ((prot_q & ~$past(pwg_lanes(i_pstrb))) ==
                                 ($past(prot_q) & ~$past(pwg_lanes(i_pstrb)))))
    else $error("write changed a bit in a disabled byte lane");
  ready_a: assert property ((i_psel && i_penable) |-> o_pready)
    else $error("access phase not answered");
  unmap_err_a: assert property (s_acc_unmapped |-> o_pslverr)
    else $error("unmapped access not flagged");
  unmap_keep_a: assert property ((s_acc_unmapped ##0 i_pwrite) |=> $stable(prot_q))
    else $error("unmapped write changed protection");
  unmap_rd_a: assert property ((setup_rd && !hit_any) |=>
                               (o_prdata == 32'h0000_0000))
    else $error("unmapped read returned data");

  // Read path
  rd_hold_a: assert property (!setup_rd |=> $stable(o_prdata))
    else $error("read data changed outside a read setup");
  rd_ok_a: assert property ((s_rd_setup ##1 (i_psel && i_penable && !i_pwrite))
                            |-> !o_pslverr)
    else $error("read of protection state flagged as error");

  // Error answers only where the rules ask for them
  set_ok_a: assert property ((s_wr_set ##0 !(|(wbits & prot_q))) |-> !o_pslverr)
    else $error("clean protect flagged as error");
  clr_ok_a: assert property ((s_wr_clr ##0 !(|(wbits & ~prot_q))) |-> !o_pslverr)
    else $error("clean unprotect flagged as error");
  tgt_err_a: assert property (o_tgt_error == o_tgt_block)
    else $error("error answer differs from block");
  blk_cause_a: assert property (o_tgt_block |->
                                (s_tgt_wr ##0 o_prot_state[i_tgt.idx]))
    else $error("block without a protected write");

  // Bit map of the first bridge
  state_mask_a: assert property ((o_prot_state & ~IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented protection bit set");
  map_irq_a: assert property ((s_wr_set ##0 wbits[PWG_BIT_EXT_IRQ])
                              |=> o_prot_state[PWG_BIT_EXT_IRQ])
    else $error("external interrupt unit bit not protected");
  map_rtc_a: assert property ((s_wr_set ##0 wbits[PWG_BIT_RTC])
                              |=> o_prot_state[PWG_BIT_RTC])
    else $error("real-time counter bit not protected");
  map_wdog_a: assert property ((s_wr_clr ##0 wbits[PWG_BIT_WDOG])
                               |=> !o_prot_state[PWG_BIT_WDOG])
    else $error("watchdog unit bit not unprotected");
  map_genclk_a: assert property ((s_wr_set ##0 wbits[PWG_BIT_GENCLK])
                                 |=> o_prot_state[PWG_BIT_GENCLK])
    else $error("generic clock unit bit not protected");
  map_sysctl_a: assert property ((s_wr_clr ##0 wbits[PWG_BIT_SYSCTL])
                                 |=> !o_prot_state[PWG_BIT_SYSCTL])
    else $error("system control unit bit not unprotected");
  map_pwr_a: assert property ((s_wr_set ##0 wbits[PWG_BIT_PWRMGR])
                              |=> o_prot_state[PWG_BIT_PWRMGR])
    else $error("power manager bit not protected");

endmodule // pwg_guard
`default_nettype wire

/* pwg_pkg.sv */
// How it works
// - One guard per bridge, covering its peripherals
// - Instances 0,1 clock on, 2 off, after reset
// - Guard keeps working in sleep while clocked
// - Debugger writes bypass protection entirely
// - Clear-location one clears protection bit
// - Set-location one sets protection bit
// - Both locations read same protection state
// - Writing zero leaves protection bit unchanged
// - Protected non-debug write blocked, error returned
// - Double protect or double unprotect gives error
// - Byte, halfword and word accesses supported
// - First instance protection resets to zero
// - Bits 6..1: irq, rtc, wdog, genclk, sysctl, power
package pwg_pkg;

  localparam logic [7:0]  PWG_OFS_CLEAR   = 8'h00;
  localparam logic [7:0]  PWG_OFS_SET     = 8'h04;
  localparam logic [31:0] PWG_PROT_RESET0 = 32'h0000_0000;
  localparam logic [31:0] PWG_IMPL_MASK0  = 32'h0000_007E;
  localparam int          PWG_BIT_EXT_IRQ = 6;
  localparam int          PWG_BIT_RTC     = 5;
  localparam int          PWG_BIT_WDOG    = 4;
  localparam int          PWG_BIT_GENCLK  = 3;
  localparam int          PWG_BIT_SYSCTL  = 2;
  localparam int          PWG_BIT_PWRMGR  = 1;
  localparam int          PWG_CLK_ON_INST = 2;

  // Access on the bridge towards one of its peripherals
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       debug;
    logic [4:0] idx;
  } pwg_tgt_t;

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] pwg_lanes(input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return m;
  endfunction

endpackage

/* pwg_bridge_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pwg_bridge_model import pwg_pkg::*; (
  input  wire logic i_ref_clk,
  output var pwg_tgt_t o_tgt
);
  initial o_tgt = '0;
  // Master side of the bridge: one peripheral access at a time
  task automatic issue(input logic w, input logic d, input logic [4:0] n);
    @(posedge i_ref_clk) #1;
    o_tgt = '{1'b1, w, d, n};
  endtask
  // Idle fields are inverted so a stale value can never look valid
  task automatic idle();
    @(posedge i_ref_clk) #1;
    o_tgt = '{1'b0, ~o_tgt.write, ~o_tgt.debug, ~o_tgt.idx};
  endtask
endmodule // pwg_bridge_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top import pwg_pkg::*; ;
  logic        clk, rst_n, psel, pen, pwr, rdy, err, blk, terr, con;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, prot;
  logic [3:0]  strb;
  pwg_tgt_t    tgt;
  int          failures, n_checks;
  pwg_guard u_pwg_guard (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
    .i_pstrb(strb), .o_prdata(rdata), .o_pready(rdy), .o_pslverr(err), .i_tgt(tgt),
    .o_tgt_block(blk), .o_tgt_error(terr), .o_prot_state(prot), .o_clk_on_rst(con));
  pwg_bridge_model u_pwg_bridge_model (.i_ref_clk(clk), .o_tgt(tgt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic e);
    @(posedge clk) #1;
    {psel, pen, pwr, addr, wdata, strb} = {3'b101, a, d, s};
    @(posedge clk) #1;
    pen = 1'b1;
    // Error and ready are combinational: look once they have settled
    @(negedge clk);
    chk({30'h0, rdy, err}, {30'h0, 1'b1, e});
    @(posedge clk) #1;
    {psel, pen} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) #1;
    {psel, pen, pwr, addr} = {3'b100, a};
    @(posedge clk) #1;
    pen = 1'b1;
    @(negedge clk);
    chk(rdata, e);
    chk({30'h0, rdy, err}, {30'h0, 1'b1, (a != PWG_OFS_CLEAR) && (a != PWG_OFS_SET)});
    @(posedge clk) #1;
    {psel, pen} = 2'b00;
  endtask
  task automatic tg(input logic w, input logic d, input logic [4:0] n, input logic e);
    u_pwg_bridge_model.issue(w, d, n);
    #1 chk({30'h0, blk, terr}, {30'h0, e, e});
    u_pwg_bridge_model.idle();
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    // About twenty-four times the length of the tests
    #20000;
    failures++;
    wrap_up();
  end
  initial begin
    {rst_n, psel, pen, pwr, addr, wdata, strb} = '0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({31'h0, con}, 32'h1);
    rd(PWG_OFS_CLEAR, 32'h0);
    rd(PWG_OFS_SET, 32'h0);
    $display("test reset done");
    wr(PWG_OFS_SET, 32'hFFFF_FF40, 4'h1, 1'b0);
    wr(PWG_OFS_SET, 32'h40, 4'hF, 1'b1);
    rd(PWG_OFS_CLEAR, 32'h40);
    wr(PWG_OFS_CLEAR, 32'h0, 4'hF, 1'b0);
    rd(PWG_OFS_SET, 32'h40);
    wr(PWG_OFS_SET, 32'h02, 4'hE, 1'b0);
    wr(PWG_OFS_CLEAR, 32'h40, 4'hE, 1'b0);
    rd(PWG_OFS_SET, 32'h40);
    tg(1'b1, 1'b0, 5'd6, 1'b1);
    tg(1'b1, 1'b1, 5'd6, 1'b0);
    tg(1'b0, 1'b0, 5'd6, 1'b0);
    tg(1'b1, 1'b0, 5'd5, 1'b0);
    wr(PWG_OFS_CLEAR, 32'h40, 4'hF, 1'b0);
    wr(PWG_OFS_CLEAR, 32'h40, 4'hF, 1'b1);
    tg(1'b1, 1'b0, 5'd6, 1'b0);
    $display("test set clear done");
    wr(8'h08, 32'hFF, 4'hF, 1'b1);
    rd(8'h08, 32'h0);
    wr(PWG_OFS_SET, 32'hFFFF_FFFF, 4'h3, 1'b0);
    chk(prot, 32'h0000_007E);
    for (int i = 1; i < 7; i++) tg(1'b1, 1'b0, i[4:0], 1'b1);
    $display("test map done");
    @(posedge clk) #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(prot, 32'h0);
    rd(PWG_OFS_SET, 32'h0);
    tg(1'b1, 1'b0, 5'd6, 1'b0);
    $display("test mid reset done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
